// file: nhc_cfg.svh
// Register map, NAND command codes, field positions and timing counts of the NAND host controller
`ifndef NHC_CFG_SVH
`define NHC_CFG_SVH

`define NHC_OFS_CTRL      8'h00
`define NHC_OFS_COL       8'h04
`define NHC_OFS_ROW       8'h08
`define NHC_OFS_LEN       8'h0c
`define NHC_OFS_WDATA     8'h10
`define NHC_OFS_STATUS    8'h14
`define NHC_OFS_ID_LO     8'h18
`define NHC_OFS_ID_HI     8'h1c

`define NHC_CTRL_OP_LSB   0
`define NHC_CTRL_WP_BIT   3
`define NHC_CTRL_CLR_BIT  8
`define NHC_CTRL_WP_RST   1'b0

`define NHC_CMD_DATA_IN   8'h80
`define NHC_CMD_CACHE_WR  8'h15
`define NHC_CMD_PROG_CONF 8'h10
`define NHC_CMD_ERASE_SET 8'h60
`define NHC_CMD_ERASE_CNF 8'hd0
`define NHC_CMD_STATUS    8'h70
`define NHC_CMD_IDENT     8'h90
`define NHC_CMD_RESET     8'hff
`define NHC_ID_ADDR       8'h00

`define NHC_ADDR_PAGE     3'd5
`define NHC_ADDR_BLOCK    3'd3
`define NHC_ADDR_ID       3'd1
`define NHC_ID_BYTES      3'd5
`define NHC_STAT_BYTES    3'd1
`define NHC_PAGE_BYTES    13'd4352
`define NHC_PAGE_WORDS    13'd2176

`define NHC_SR_CUR_FAIL   0
`define NHC_SR_PREV_FAIL  1
`define NHC_SR_PROG_IDLE  5
`define NHC_SR_CACHE_RDY  6
`define NHC_SR_UNPROT     7

`define NHC_ID3_DIE_LSB   0
`define NHC_ID3_CELL_LSB  2
`define NHC_ID3_SIM_LSB   4
`define NHC_ID3_ILV_BIT   6
`define NHC_ID3_CACHE_BIT 7

`define NHC_CLK_NS        100
`define NHC_T_STROBE_NS   50
`define NHC_T_WB_NS       200
`define NHC_STROBE_CYC    ((`NHC_T_STROBE_NS + `NHC_CLK_NS - 1) / `NHC_CLK_NS)
`define NHC_WB_CYC        ((`NHC_T_WB_NS + `NHC_CLK_NS - 1) / `NHC_CLK_NS)

`endif

// file: nhc_pkg.sv
// Types shared by the NAND host controller modules
package nhc_pkg;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_LOAD  = 3'h1,
    OP_PROG  = 3'h2,
    OP_ERASE = 3'h3,
    OP_STAT  = 3'h4,
    OP_ID    = 3'h5,
    OP_RST   = 3'h6,
    OP_BAD   = 3'h7
  } nhc_op_e;

  typedef enum logic [1:0] {
    CYC_CMD  = 2'h0,
    CYC_ADDR = 2'h1,
    CYC_WR   = 2'h2,
    CYC_RD   = 2'h3
  } nhc_cyc_e;

  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_PRERB  = 9'h002,
    S_CMD1   = 9'h004,
    S_ADDR   = 9'h008,
    S_WDAT   = 9'h010,
    S_CMD2   = 9'h020,
    S_RDAT   = 9'h040,
    S_TWB    = 9'h080,
    S_POSTRB = 9'h100
  } nhc_state_e;

  typedef enum logic [3:0] {
    P_IDLE  = 4'h1,
    P_SETUP = 4'h2,
    P_LOW   = 4'h4,
    P_HIGH  = 4'h8
  } nhc_pin_e;

  typedef struct packed {
    logic [7:0] cmd1;
    logic [2:0] addr_n;
    logic       data;
    logic       has2;
    logic [7:0] cmd2;
    logic [2:0] rd_n;
    logic       pre;
  } nhc_seq_s;

endpackage : nhc_pkg

// file: nhc_cyc_if.sv
// One bus-cycle request between the sequencer and the pin driver
`timescale 1ns/1ps
interface nhc_cyc_if #(parameter int DW = 8);
  logic              req;
  nhc_pkg::nhc_cyc_e kind;
  logic [DW-1:0]     wdata;
  logic              done;
  logic [DW-1:0]     rdata;

  modport seq (input req, input kind, input wdata, output done, output rdata);
  modport ctl (output req, output kind, output wdata, input done, input rdata);
endinterface : nhc_cyc_if

// file: nhc_pin_seq.sv
// Pin driver: one command, address, data-in or data-out cycle on the NAND bus
`timescale 1ns/1ps
`include "nhc_cfg.svh"
module nhc_pin_seq #(
  parameter int DW         = 8,
  parameter int STROBE_CYC = `NHC_STROBE_CYC
) (
  input  wire logic          pclk,     // System clock
  input  wire logic          presetn,  // Async reset, active low
  nhc_cyc_if.seq             cyc,      // Cycle request from sequencer
  input  wire logic [DW-1:0] dq_in,    // Bus level from device
  output logic               cle,      // Command latch enable
  output logic               ale,      // Address latch enable
  output logic               we_n,     // Write strobe
  output logic               read_strobe_n, // Read strobe
  output logic [DW-1:0]      dq_out,   // Bus drive value
  output logic               dq_oe     // Bus driven when high
);

  // The strobe counter is four bits wide
  if (STROBE_CYC < 1 || STROBE_CYC > 15) $error("nhc_pin_seq: STROBE_CYC out of range");

  nhc_pkg::nhc_pin_e state_ff;
  logic [3:0]        cnt_ff;
  logic              rd_ff;
  logic [DW-1:0]     rdata_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= nhc_pkg::P_IDLE;
      cnt_ff   <= 4'h0;
    end
    else
    begin
      case (state_ff)
        nhc_pkg::P_IDLE:  if (cyc.req) state_ff <= nhc_pkg::P_SETUP;
        nhc_pkg::P_SETUP:
        begin
          state_ff <= nhc_pkg::P_LOW;
          cnt_ff   <= 4'(STROBE_CYC - 1);
        end
        nhc_pkg::P_LOW:
        begin
          if (cnt_ff == 4'h0) state_ff <= nhc_pkg::P_HIGH;
          else cnt_ff <= cnt_ff - 4'h1;
        end
        nhc_pkg::P_HIGH:  state_ff <= nhc_pkg::P_IDLE;
        default:          state_ff <= nhc_pkg::P_IDLE;
      endcase
    end
  end

  // Data stays driven through the high phase to cover the hold time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cle           <= 1'b0;
      ale           <= 1'b0;
      we_n          <= 1'b1;
      read_strobe_n <= 1'b1;
      dq_out        <= '0;
      dq_oe         <= 1'b0;
      rd_ff         <= 1'b0;
      rdata_ff      <= '0;
    end
    else
    begin
      if (state_ff == nhc_pkg::P_IDLE && cyc.req)
      begin
        cle    <= cyc.kind == nhc_pkg::CYC_CMD;
        ale    <= cyc.kind == nhc_pkg::CYC_ADDR;
        dq_out <= cyc.wdata;
        dq_oe  <= cyc.kind != nhc_pkg::CYC_RD;
        rd_ff  <= cyc.kind == nhc_pkg::CYC_RD;
      end
      if (state_ff == nhc_pkg::P_SETUP)
      begin
        we_n          <= rd_ff;
        read_strobe_n <= !rd_ff;
      end
      if (state_ff == nhc_pkg::P_LOW && cnt_ff == 4'h0)
      begin
        we_n          <= 1'b1;
        read_strobe_n <= 1'b1;
        if (rd_ff) rdata_ff <= dq_in;
      end
      if (state_ff == nhc_pkg::P_HIGH)
      begin
        cle   <= 1'b0;
        ale   <= 1'b0;
        dq_oe <= 1'b0;
      end
    end
  end

  assign cyc.done  = state_ff == nhc_pkg::P_HIGH;
  assign cyc.rdata = rdata_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_STROBE_EXCL: assert property (!(!we_n && !read_strobe_n))
    else $error("write and read strobe low together");
  AST_READ_NO_DRIVE: assert property (!read_strobe_n |-> !dq_oe)
    else $error("bus driven during read strobe");
  AST_DONE_BOUND: assert property ((state_ff == nhc_pkg::P_IDLE && cyc.req) |-> ##[3:18] cyc.done)
    else $error("bus cycle did not complete in time");
  AST_WE_RISE_DONE: assert property ($rose(we_n) |-> cyc.done && (cle || ale || dq_oe))
    else $error("write strobe rose outside cycle end");

endmodule : nhc_pin_seq

// file: nhc_top.sv
// NAND host controller: APB registers, operation sequencer and NAND pin driver
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "nhc_cfg.svh"
module nhc_top #(
  parameter int DW        = 8,
  parameter int PAGE_BITS = 6,
  parameter int WB_CYC    = `NHC_WB_CYC
) (
  input  wire logic          pclk,          // System clock, 10 MHz
  input  wire logic          presetn,       // Async reset, active low
  input  wire logic [7:0]    paddr,         // APB address
  input  wire logic          psel,          // APB select
  input  wire logic          penable,       // APB enable
  input  wire logic          pwrite,        // APB direction
  input  wire logic [31:0]   pwdata,        // APB write data
  output logic [31:0]        prdata,        // APB read data
  output logic               pready,        // APB ready
  output logic               pslverr,       // APB error
  output logic               ce_n,          // NAND chip enable
  output logic               cle,           // NAND command latch
  output logic               ale,           // NAND address latch
  output logic               we_n,          // NAND write strobe
  output logic               read_strobe_n, // NAND read strobe
  output logic               wp_n,          // NAND write protect
  input  wire logic [DW-1:0] dq_in,         // NAND bus in
  output logic [DW-1:0]      dq_out,        // NAND bus out
  output logic               dq_oe,         // NAND bus drive enable
  input  wire logic          ready_busy_pin // NAND ready/busy
);

  localparam int BLK_W = 24 - PAGE_BITS;

  // Refuse sizes that the counters and the row split cannot hold
  if (DW != 8 && DW != 16) $error("nhc_top: DW must be 8 or 16");
  if (PAGE_BITS < 1 || PAGE_BITS > 12) $error("nhc_top: PAGE_BITS out of range");
  if (WB_CYC < 1 || WB_CYC > 255) $error("nhc_top: WB_CYC out of range");

  localparam logic [12:0] PAGE_LEN = (DW == 16) ? `NHC_PAGE_WORDS : `NHC_PAGE_BYTES;

  nhc_cyc_if #(.DW(DW)) cyc ();

  nhc_pkg::nhc_state_e state_ff;
  nhc_pkg::nhc_op_e    op_ff;
  nhc_pkg::nhc_op_e    try_op;
  nhc_pkg::nhc_seq_s   seq;
  nhc_pkg::nhc_seq_s   try_seq;
  logic [12:0]         cnt_ff;
  logic [7:0]          wb_ff;
  logic [15:0]         col_ff;
  logic [23:0]         row_ff;
  logic [12:0]         len_ff;
  logic [DW-1:0]       wdat_ff;
  logic                wdat_full_ff;
  logic                wp_en_ff;
  logic                refused_ff;
  logic                cache_open_ff;
  logic [BLK_W-1:0]    cache_blk_ff;
  logic [7:0]          stat_ff;
  logic [7:0]          id_ff [0:4];
  logic [31:0]         prdata_ff;
  logic                wr;
  logic                start;
  logic                refuse;
  logic                blk_ok;
  logic                is_prog;

  function automatic nhc_pkg::nhc_seq_s seq_of(input nhc_pkg::nhc_op_e op);
    nhc_pkg::nhc_seq_s s;
    s = '0;
    case (op)
      nhc_pkg::OP_LOAD:  s = '{`NHC_CMD_DATA_IN, `NHC_ADDR_PAGE, 1'b1, 1'b1, `NHC_CMD_CACHE_WR, 3'd0, 1'b1};
      nhc_pkg::OP_PROG:  s = '{`NHC_CMD_DATA_IN, `NHC_ADDR_PAGE, 1'b1, 1'b1, `NHC_CMD_PROG_CONF, 3'd0, 1'b1};
      nhc_pkg::OP_ERASE: s = '{`NHC_CMD_ERASE_SET, `NHC_ADDR_BLOCK, 1'b0, 1'b1, `NHC_CMD_ERASE_CNF, 3'd0, 1'b1};
      nhc_pkg::OP_STAT:  s = '{`NHC_CMD_STATUS, 3'd0, 1'b0, 1'b0, 8'h00, `NHC_STAT_BYTES, 1'b0};
      nhc_pkg::OP_ID:    s = '{`NHC_CMD_IDENT, `NHC_ADDR_ID, 1'b0, 1'b0, 8'h00, `NHC_ID_BYTES, 1'b1};
      nhc_pkg::OP_RST:   s = '{`NHC_CMD_RESET, 3'd0, 1'b0, 1'b0, 8'h00, 3'd0, 1'b0};
      default:           s = '0;
    endcase
    return s;
  endfunction : seq_of

  function automatic logic [7:0] addr_byte(input nhc_pkg::nhc_op_e op, input logic [2:0] idx,
                                           input logic [15:0] col, input logic [23:0] row);
    logic [39:0] all;
    all = (op == nhc_pkg::OP_ERASE) ? {16'h0000, row} :
          (op == nhc_pkg::OP_ID)    ? {32'h0000_0000, `NHC_ID_ADDR} : {row, col};
    return all[{idx, 3'b000} +: 8];
  endfunction : addr_byte

  function automatic logic hit(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= `NHC_OFS_ID_HI;
  endfunction : hit

  // Stalling a data write while the holding register is full keeps the page stream lossless
  assign pready  = !(psel && penable && pwrite && paddr == `NHC_OFS_WDATA && wdat_full_ff);
  assign pslverr = psel && penable && !hit(paddr);
  assign prdata  = prdata_ff;
  assign wr      = psel && penable && pready && pwrite && hit(paddr);
  assign start   = wr && paddr == `NHC_OFS_CTRL && pwdata[`NHC_CTRL_OP_LSB +: 3] != 3'h0;

  always_comb
  begin
    try_op  = nhc_pkg::nhc_op_e'(pwdata[`NHC_CTRL_OP_LSB +: 3]);
    try_seq = seq_of(try_op);
    seq     = seq_of(op_ff);
    is_prog = try_op == nhc_pkg::OP_LOAD || try_op == nhc_pkg::OP_PROG;
    blk_ok  = row_ff[23:PAGE_BITS] == cache_blk_ff;
    refuse  = state_ff != nhc_pkg::S_IDLE || try_op == nhc_pkg::OP_BAD;
    if (cache_open_ff && !(is_prog || try_op == nhc_pkg::OP_STAT || try_op == nhc_pkg::OP_RST))
      refuse = 1'b1;
    if (cache_open_ff && is_prog && !blk_ok)
      refuse = 1'b1;
    if (is_prog && (len_ff == 13'd0 || len_ff > PAGE_LEN))
      refuse = 1'b1;
  end

  always_comb
  begin
    cyc.req   = 1'b0;
    cyc.kind  = nhc_pkg::CYC_CMD;
    cyc.wdata = '0;
    case (state_ff)
      nhc_pkg::S_CMD1:
      begin
        cyc.req   = 1'b1;
        cyc.wdata = DW'(seq.cmd1);
      end
      nhc_pkg::S_ADDR:
      begin
        cyc.req   = 1'b1;
        cyc.kind  = nhc_pkg::CYC_ADDR;
        cyc.wdata = DW'(addr_byte(op_ff, cnt_ff[2:0], col_ff, row_ff));
      end
      nhc_pkg::S_WDAT:
      begin
        cyc.req   = wdat_full_ff;
        cyc.kind  = nhc_pkg::CYC_WR;
        cyc.wdata = wdat_ff;
      end
      nhc_pkg::S_CMD2:
      begin
        cyc.req   = 1'b1;
        cyc.wdata = DW'(seq.cmd2);
      end
      nhc_pkg::S_RDAT:
      begin
        cyc.req   = 1'b1;
        cyc.kind  = nhc_pkg::CYC_RD;
      end
      default: cyc.req = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= nhc_pkg::S_IDLE;
      op_ff    <= nhc_pkg::OP_NONE;
      cnt_ff   <= 13'd0;
      wb_ff    <= 8'h00;
    end
    else
    begin
      case (state_ff)
        nhc_pkg::S_IDLE:
          if (start && !refuse)
          begin
            op_ff    <= try_op;
            cnt_ff   <= 13'd0;
            state_ff <= try_seq.pre ? nhc_pkg::S_PRERB : nhc_pkg::S_CMD1;
          end
        nhc_pkg::S_PRERB:  if (ready_busy_pin) state_ff <= nhc_pkg::S_CMD1;
        // each op issues its own command
        // Reset goes straight to the busy wait, so the delay is armed here as well
        nhc_pkg::S_CMD1:
          if (cyc.done)
          begin
            state_ff <= seq.addr_n != 3'd0 ? nhc_pkg::S_ADDR :
                        seq.rd_n != 3'd0   ? nhc_pkg::S_RDAT : nhc_pkg::S_TWB;
            wb_ff    <= 8'(WB_CYC);
          end
        nhc_pkg::S_ADDR:
          if (cyc.done)
          begin
            if (cnt_ff[2:0] == seq.addr_n - 3'd1)
            begin
              state_ff <= seq.data ? nhc_pkg::S_WDAT : seq.has2 ? nhc_pkg::S_CMD2 : nhc_pkg::S_RDAT;
              if (seq.data || !seq.has2) cnt_ff <= 13'd0;
            end
            else cnt_ff <= cnt_ff + 13'd1;
          end
        nhc_pkg::S_WDAT:
          if (cyc.done)
          begin
            if (cnt_ff == len_ff - 13'd1) state_ff <= nhc_pkg::S_CMD2;
            else cnt_ff <= cnt_ff + 13'd1;
          end
        nhc_pkg::S_CMD2:
          if (cyc.done)
          begin
            state_ff <= nhc_pkg::S_TWB;
            wb_ff    <= 8'(WB_CYC);
          end
        nhc_pkg::S_RDAT:
          if (cyc.done)
          begin
            if (cnt_ff[2:0] == seq.rd_n - 3'd1) state_ff <= nhc_pkg::S_IDLE;
            else cnt_ff <= cnt_ff + 13'd1;
          end
        // Ready/busy only falls some time after the strobe, so it is not trusted at once
        nhc_pkg::S_TWB:
          if (wb_ff <= 8'h01) state_ff <= nhc_pkg::S_POSTRB;
          else wb_ff <= wb_ff - 8'h01;
        nhc_pkg::S_POSTRB: if (ready_busy_pin) state_ff <= nhc_pkg::S_IDLE;
        default:           state_ff <= nhc_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      col_ff   <= 16'h0000;
      row_ff   <= 24'h00_0000;
      len_ff   <= 13'd0;
      wp_en_ff <= `NHC_CTRL_WP_RST;
    end
    else if (wr)
    begin
      if (paddr == `NHC_OFS_CTRL) wp_en_ff <= pwdata[`NHC_CTRL_WP_BIT];
      if (state_ff == nhc_pkg::S_IDLE)
      begin
        if (paddr == `NHC_OFS_COL) col_ff <= pwdata[15:0];
        if (paddr == `NHC_OFS_ROW) row_ff <= pwdata[23:0];
        if (paddr == `NHC_OFS_LEN) len_ff <= pwdata[12:0];
      end
    end
  end

  assign wp_n = wp_en_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdat_ff      <= '0;
      wdat_full_ff <= 1'b0;
      refused_ff   <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `NHC_OFS_WDATA) wdat_ff <= pwdata[DW-1:0];
      wdat_full_ff <= (wr && paddr == `NHC_OFS_WDATA) ||
                      (wdat_full_ff && !(state_ff == nhc_pkg::S_WDAT && cyc.done));
      refused_ff   <= (start && refuse) ||
                      (refused_ff && !(wr && paddr == `NHC_OFS_CTRL && pwdata[`NHC_CTRL_CLR_BIT]));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cache_open_ff <= 1'b0;
      cache_blk_ff  <= '0;
      stat_ff       <= 8'h00;
    end
    else
    begin
      if (state_ff == nhc_pkg::S_POSTRB && ready_busy_pin)
      begin
        if (op_ff == nhc_pkg::OP_LOAD)
        begin
          cache_open_ff <= 1'b1;
          cache_blk_ff  <= row_ff[23:PAGE_BITS];
        end
        else if (op_ff == nhc_pkg::OP_PROG || op_ff == nhc_pkg::OP_RST) cache_open_ff <= 1'b0;
      end
      if (state_ff == nhc_pkg::S_RDAT && cyc.done && op_ff == nhc_pkg::OP_STAT)
      begin
        stat_ff <= cyc.rdata[7:0];
        if (cyc.rdata[`NHC_SR_PROG_IDLE]) cache_open_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 5; i++) id_ff[i] <= 8'h00;
    end
    else if (state_ff == nhc_pkg::S_RDAT && cyc.done && op_ff == nhc_pkg::OP_ID)
      id_ff[cnt_ff[2:0]] <= cyc.rdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) prdata_ff <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `NHC_OFS_CTRL:   prdata_ff <= {28'h000_0000, wp_en_ff, 3'h0};
        `NHC_OFS_COL:    prdata_ff <= {16'h0000, col_ff};
        `NHC_OFS_ROW:    prdata_ff <= {8'h00, row_ff};
        `NHC_OFS_LEN:    prdata_ff <= {19'h0_0000, len_ff};
        `NHC_OFS_WDATA:  prdata_ff <= 32'(wdat_ff);
        `NHC_OFS_STATUS: prdata_ff <= {16'h0000, stat_ff, 4'h0, cache_open_ff, refused_ff,
                                       ready_busy_pin, state_ff != nhc_pkg::S_IDLE};
        `NHC_OFS_ID_LO:  prdata_ff <= {id_ff[3], id_ff[2], id_ff[1], id_ff[0]};
        `NHC_OFS_ID_HI:  prdata_ff <= {16'h0000, id_ff[2][`NHC_ID3_CACHE_BIT], id_ff[2][`NHC_ID3_ILV_BIT],
                                       id_ff[2][`NHC_ID3_SIM_LSB +: 2], id_ff[2][`NHC_ID3_CELL_LSB +: 2],
                                       id_ff[2][`NHC_ID3_DIE_LSB +: 2], id_ff[4]};
        default:         prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) ce_n <= 1'b1;
    else ce_n <= state_ff == nhc_pkg::S_IDLE;
  end

  nhc_pin_seq #(.DW(DW)) u_pins (
    .pclk          (pclk),
    .presetn       (presetn),
    .cyc           (cyc.seq),
    .dq_in         (dq_in),
    .cle           (cle),
    .ale           (ale),
    .we_n          (we_n),
    .read_strobe_n (read_strobe_n),
    .dq_out        (dq_out),
    .dq_oe         (dq_oe)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ERASE_THREE_ADDR: assert property ((state_ff == nhc_pkg::S_CMD2 && op_ff == nhc_pkg::OP_ERASE) |-> cnt_ff == 13'd2)
    else $error("erase confirm after wrong address count");
  AST_BUSY_GUARD: assert property ((state_ff == nhc_pkg::S_PRERB && ready_busy_pin) |=> state_ff == nhc_pkg::S_CMD1)
    else $error("command not issued after ready");
  AST_CACHE_POLL: assert property ((start && cache_open_ff && try_op == nhc_pkg::OP_ERASE) |=> refused_ff && state_ff == nhc_pkg::S_IDLE)
    else $error("op accepted before idle poll");
  AST_SAME_BLOCK: assert property ((state_ff == nhc_pkg::S_CMD1 && op_ff == nhc_pkg::OP_LOAD && cache_open_ff) |-> blk_ok)
    else $error("cache load crosses block");
  AST_STATUS_TAKE: assert property ((state_ff == nhc_pkg::S_RDAT && cyc.done && op_ff == nhc_pkg::OP_STAT) |=> stat_ff == $past(cyc.rdata[7:0]))
    else $error("status byte not captured");
  AST_POST_WAIT: assert property ((state_ff == nhc_pkg::S_POSTRB && !ready_busy_pin) |=> state_ff == nhc_pkg::S_POSTRB)
    else $error("left busy wait early");

  COV_ERASE: cover property (state_ff == nhc_pkg::S_POSTRB && op_ff == nhc_pkg::OP_ERASE && ready_busy_pin);
  COV_CACHE: cover property (state_ff == nhc_pkg::S_POSTRB && op_ff == nhc_pkg::OP_LOAD && ready_busy_pin);
  COV_ID:    cover property (state_ff == nhc_pkg::S_RDAT && op_ff == nhc_pkg::OP_ID && cyc.done && cnt_ff == 13'd4);

endmodule : nhc_top

// file: nhc_dev.sv
// Behavioural NAND device facing the controller pins
`timescale 1ns/1ps
module nhc_dev (
  input  wire logic       ce_n,          // Chip enable
  input  wire logic       cle,           // Command latch
  input  wire logic       ale,           // Address latch
  input  wire logic       dq_oe,         // Controller drives bus
  input  wire logic       we_n,          // Write strobe
  input  wire logic       read_strobe_n, // Read strobe
  input  wire logic       wp_n,          // Write protect
  input  wire logic [7:0] dq_out,        // Bus from controller
  output logic      [7:0] dq_in,         // Bus to controller
  output logic            ready_busy_pin // Ready high
);
  // Identifier values are arbitrary; third byte holds fields 3,2,1,0,1
  localparam logic [7:0] ID [5] = '{8'h5a, 8'h5b, 8'h9b, 8'h5d, 8'h5e};
  logic [7:0] cmd, prev, sr, v;
  logic [2:0] n;
  logic       run;
  int         busy, n_erase, n_prog, n_addr;
  initial {cmd, prev, n, run, busy, n_erase, n_prog, n_addr} = '0;
  always @(posedge we_n) if (!ce_n && ale && dq_oe) n_addr++;
  always #100 if (busy > 0) busy--;
  assign sr = {wp_n, busy == 0, busy == 0, 5'h00};
  assign ready_busy_pin = busy == 0;
  assign v = cmd == 8'h70 ? sr : ID[n];
  // Released bus shows the inverse so a stale sample cannot match
  assign dq_in = (!ce_n && !read_strobe_n) ? v : ~v;
  always @(posedge read_strobe_n) if (n < 3'd4) n++;
  // only status or reset while busy
  always @(posedge we_n) if (!ce_n && cle && dq_oe && (busy == 0 || dq_out == 8'h70 || dq_out == 8'hff))
  begin
    prev = cmd;
    cmd = dq_out;
    n = 0;
    if (cmd == 8'hd0 && prev == 8'h60 && wp_n)
    begin
      busy = 20;
      n_erase++;
    end
    // cache confirm waits for programming in flight
    if (cmd == 8'h15 && wp_n)
    begin
      busy = run ? 8 : 3;
      run = 1;
      n_prog++;
    end
    if (cmd == 8'h10 && wp_n)
    begin
      busy = 8;
      run = 0;
      n_prog++;
    end
    if (cmd == 8'hff)
    begin
      busy = 2;
      run = 0;
    end
  end
endmodule : nhc_dev

// file: nand_cache_program_erase_status_id_test.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/1ps
module nand_cache_program_erase_status_id_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic        ce_n, cle, ale, we_n, read_strobe_n, wp_n, dq_oe, ready_busy_pin;
  logic [7:0]  paddr, dq_in, dq_out;
  logic [31:0] pwdata, prdata, q;
  int          n_errors = 0, checks = 0, cyc = 0;
  nhc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .ready_busy_pin(ready_busy_pin));
  nhc_dev dev (.ce_n(ce_n), .cle(cle), .ale(ale), .dq_oe(dq_oe), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
    .dq_out(dq_out), .dq_in(dq_in), .ready_busy_pin(ready_busy_pin));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Whole run needs a few hundred cycles; this ceiling cuts a hang
  always @(posedge pclk) if (++cyc == 60000)
  begin
    n_errors++;
    summarize();
  end
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  // Start an operation, feed page words, then poll until not busy
  task automatic op(input logic [31:0] c, input int nw);
    bus(1'b1, 8'h00, c);
    repeat (nw) bus(1'b1, 8'h10, 32'h0000_00a5);
    for (int i = 0; i < 300; i++)
    begin
      bus(1'b0, 8'h14, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk("op done", {31'h0, q[0]}, 32'h0);
  endtask : op
  task automatic t_regs();
    bus(1'b0, 8'h14, 32'h0);
    chk("status idle", {28'h0, q[3:0]}, 32'h2);
    chk("wp reset", {31'h0, wp_n}, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped err", {31'h0, perr}, 32'h1);
    bus(1'b1, 8'h00, 32'h7);
    bus(1'b0, 8'h14, 32'h0);
    chk("refused", {31'h0, q[2]}, 32'h1);
    bus(1'b1, 8'h00, 32'h100);
    bus(1'b0, 8'h14, 32'h0);
    chk("refused clr", {31'h0, q[2]}, 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_ident();
    op(32'h5, 0);
    bus(1'b0, 8'h18, 32'h0);
    chk("id lo", q, 32'h5d9b5b5a);
    bus(1'b0, 8'h1c, 32'h0);
    chk("id hi", {16'h0, q[15:0]}, 32'h9b5e);
    $display("ident done");
  endtask : t_ident
  task automatic t_erase();
    op(32'h3, 0);
    op(32'h4, 0);
    chk("prot status", {24'h0, q[15:8]}, 32'h60);
    chk("prot erase", dev.n_erase, 0);
    op(32'hb, 0);
    chk("erase count", dev.n_erase, 1);
    chk("address cycles", dev.n_addr, 7);
    op(32'hc, 0);
    chk("erase status", {24'h0, q[15:8]}, 32'he0);
    $display("erase done");
  endtask : t_erase
  task automatic t_cache();
    bus(1'b1, 8'h08, 32'h40);
    bus(1'b1, 8'h0c, 32'h2);
    op(32'h9, 2);
    op(32'h9, 2);
    chk("cache open", {31'h0, q[3]}, 32'h1);
    op(32'hb, 0);
    chk("erase in cache", {31'h0, q[2]}, 32'h1);
    bus(1'b1, 8'h00, 32'h108);
    bus(1'b1, 8'h08, 32'h80);
    op(32'h9, 0);
    chk("cross block", {31'h0, q[2]}, 32'h1);
    bus(1'b1, 8'h08, 32'h40);
    bus(1'b1, 8'h00, 32'h108);
    op(32'ha, 2);
    chk("cache closed", {31'h0, q[3]}, 32'h0);
    chk("pages", dev.n_prog, 3);
    op(32'he, 0);
    op(32'hc, 0);
    chk("reset status", {24'h0, q[15:8]}, 32'he0);
    $display("cache done");
  endtask : t_cache
  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ident();
    t_erase();
    t_cache();
    summarize();
  end
endmodule : nand_cache_program_erase_status_id_test
